// ---- hw/dbc_pkg.sv ----
// constants, types and helpers shared by the bank command logic
package dbc_pkg;

    // ========================================================
    // widths and sizes
    localparam int DBC_BANKS     = 8;
    localparam int DBC_BA_W      = 3;
    localparam int DBC_ADDR_W    = 15;
    localparam int DBC_COL_W     = 11;
    localparam int DBC_DATA_W    = 16;
    localparam int DBC_MASK_W    = 2;
    localparam int DBC_FIFO_DEPTH = 8;
    localparam int DBC_MODE_REGS = 4;
    localparam int DBC_POST_DEPTH = 7;

    // ========================================================
    // address fields
    localparam int DBC_PRE_ALL_BIT = 10;
    localparam int DBC_COL_HI_BIT  = 11;

    // ========================================================
    // posted command entry {valid, write, auto precharge, bank, column}
    localparam int DBC_ENT_W     = 17;
    localparam int DBC_ENT_VALID = 16;
    localparam int DBC_ENT_WR    = 15;
    localparam int DBC_ENT_AP    = 14;
    localparam int DBC_ENT_BA_LO = 11;

    // ========================================================
    // command codes on {select, row strobe, column strobe, write enable}
    localparam logic [3:0] DBC_CMD_MODE  = 4'h0;
    localparam logic [3:0] DBC_CMD_REF   = 4'h1;
    localparam logic [3:0] DBC_CMD_PRE   = 4'h2;
    localparam logic [3:0] DBC_CMD_ACT   = 4'h3;
    localparam logic [3:0] DBC_CMD_WRITE = 4'h4;
    localparam logic [3:0] DBC_CMD_READ  = 4'h5;
    localparam logic [3:0] DBC_CMD_NOP   = 4'h7;

    // ========================================================
    // timing
    localparam int DBC_CLK_PERIOD_PS = 50000;
    localparam int DBC_PRECHARGE_PERIOD_PS = 15000;
    localparam int DBC_ACT_TO_ACCESS_PS    = 15000;
    localparam int DBC_PRECHARGE_CYC =
        (DBC_PRECHARGE_PERIOD_PS + DBC_CLK_PERIOD_PS - 1)
        / DBC_CLK_PERIOD_PS;
    localparam int DBC_ACT_TO_ACCESS_CYC =
        (DBC_ACT_TO_ACCESS_PS + DBC_CLK_PERIOD_PS - 1)
        / DBC_CLK_PERIOD_PS;
    localparam logic [5:0] DBC_MODE_LOAD_GAP_CYC = 6'h02;

    // ========================================================
    // reset values
    localparam logic [DBC_ADDR_W-1:0] DBC_MODE_RST = 15'h0000;
    localparam logic [DBC_ADDR_W-1:0] DBC_REF_ROW_RST = 15'h0000;

    typedef logic [5:0] dbc_timer_t;

    typedef enum logic [2:0] {
        BK_IDLE,
        BK_OPENING,
        BK_ACTIVE,
        BK_AP_WAIT,
        BK_PRECHG
    } dbc_bank_e;

    // clock cycles per burst: half the burst length
    function automatic dbc_timer_t dbc_half_burst(input logic bl8);
        return bl8 ? 6'h04 : 6'h02;
    endfunction

endpackage

// ---- hw/dbc_fifo.sv ----
// write data fifo with valid/ready on both sides
`timescale 1ns/1ps
module dbc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // ========================================================
    // pointers and occupancy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clk_en) begin
            if (push)
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (clk_en && push)
            mem[wr_ptr] <= in_data;
    end

    fifo_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        count <= (PW+1)'(DEPTH))
        else $error("fifo occupancy above depth");

endmodule

// ---- hw/dbc_cmd.sv ----
// bank command decode, per-bank state and write data path
//
// Notes on behaviour
// [RQ1] commands count only with cke high now and last cycle
// [RQ2] bank idle only after precharge period and no read burst
// [RQ3] row active once open, gap met, no burst or mode load busy
// [RQ4] read auto precharge starts half a burst after internal read
// [RQ5] write auto precharge starts after latency, burst and recovery
// [RQ6] other banks accept commands during auto precharge
// [RQ7] controller refreshes or loads modes only with all banks idle
// [RQ8] sequences not allowed are illegal; controller must avoid them
// [RQ9] controller keeps write-to-read gap of at least two clocks
// [RQ10] controller spaces commands after write with auto precharge
// [RQ11] controller spaces commands after read with auto precharge
// [RQ12] deselect registers nothing; running work carries on
// [RQ13] no-operation does nothing; running work carries on
// [RQ14] mode load stores address in register chosen by bank bits
// [RQ15] activate opens given row in given bank until precharged
// [RQ16] controller precharges before new row, activates before access
// [RQ17] read starts burst; bit ten selects auto precharge
// [RQ18] write starts burst; bit ten selects auto precharge
// [RQ19] reads and writes posted by the additive latency
// [RQ20] beats with mask low are stored, mask high leaves location
// [RQ21] precharge closes one or all banks for the precharge period
// [RQ22] precharge to idle or precharging bank allowed; last one times
// [RQ23] refresh address comes from internal counter, address ignored
// [RQ24] decode of activate, read, write and precharge codes
// [RQ25] bit ten high precharges all banks, low only the addressed one
`timescale 1ns/1ps
module dbc_cmd
    import dbc_pkg::*;
(
    // clock, reset, freeze
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        clk_en,
    // command pins
    input  wire logic                        cke,
    input  wire logic                        cs_n,
    input  wire logic                        ras_n,
    input  wire logic                        cas_n,
    input  wire logic                        we_n,
    input  wire logic [dbc_pkg::DBC_BA_W-1:0]   ba,
    input  wire logic [dbc_pkg::DBC_ADDR_W-1:0] addr,
    // settings
    input  wire logic [2:0]                  read_latency_setting,
    input  wire logic                        burst_length_setting,
    input  wire logic [2:0]                  additive_latency,
    input  wire logic [2:0]                  write_recovery_time,
    // write data in
    input  wire logic                        wdata_valid,
    input  wire logic [dbc_pkg::DBC_DATA_W-1:0] wdata,
    input  wire logic [dbc_pkg::DBC_MASK_W-1:0] write_byte_mask,
    output logic                             wdata_ready,
    // array write port
    output logic                             arr_wr_valid,
    input  wire logic                        arr_wr_ready,
    output logic [dbc_pkg::DBC_BA_W-1:0]     arr_wr_bank,
    output logic [dbc_pkg::DBC_ADDR_W-1:0]   arr_wr_row,
    output logic [dbc_pkg::DBC_COL_W-1:0]    arr_wr_col,
    output logic [dbc_pkg::DBC_DATA_W-1:0]   arr_wr_data,
    output logic [dbc_pkg::DBC_MASK_W-1:0]   arr_wr_byte_en,
    // array read start
    output logic                             rd_start,
    output logic [dbc_pkg::DBC_BA_W-1:0]     rd_bank,
    output logic [dbc_pkg::DBC_ADDR_W-1:0]   rd_row,
    output logic [dbc_pkg::DBC_COL_W-1:0]    rd_col,
    // refresh
    output logic                             refresh_pulse,
    output logic [dbc_pkg::DBC_ADDR_W-1:0]   refresh_row,
    // mode registers
    input  wire logic [1:0]                  mode_sel,
    output logic [dbc_pkg::DBC_ADDR_W-1:0]   mode_data,
    output logic                             mode_busy,
    // status
    output logic [dbc_pkg::DBC_BANKS-1:0]    bank_idle,
    output logic [dbc_pkg::DBC_BANKS-1:0]    bank_row_active,
    output logic                             rd_busy,
    output logic                             wr_busy
);
    import dbc_pkg::*;

    // ========================================================
    // state
    dbc_bank_e             bank_state [DBC_BANKS];
    dbc_timer_t            bank_timer [DBC_BANKS];
    logic [DBC_ADDR_W-1:0] bank_row   [DBC_BANKS];
    logic [DBC_ENT_W-1:0]  post_pipe  [DBC_POST_DEPTH];
    logic [DBC_ADDR_W-1:0] mode_regs  [DBC_MODE_REGS];
    logic                  cke_prev;
    dbc_timer_t            mode_timer;
    dbc_timer_t            rd_left;
    logic [DBC_BA_W-1:0]   rd_burst_bank;
    logic [3:0]            wr_left;
    logic [DBC_BA_W-1:0]   wr_bank;
    logic [DBC_COL_W-1:0]  wr_col;

    // ========================================================
    // command decode
    wire [3:0] cmd_code = {cs_n, ras_n, cas_n, we_n};
    // deselect and no-operation fall through every match below
    wire cmd_live = cke_prev && cke && !cs_n && !mode_busy; // RQ1 RQ12 RQ13
    wire act_cmd  = cmd_live && cmd_code == DBC_CMD_ACT;   // RQ24
    wire rd_cmd   = cmd_live && cmd_code == DBC_CMD_READ;  // RQ24
    wire wr_cmd   = cmd_live && cmd_code == DBC_CMD_WRITE; // RQ24
    wire pre_cmd  = cmd_live && cmd_code == DBC_CMD_PRE;   // RQ24
    wire ref_cmd  = cmd_live && cmd_code == DBC_CMD_REF;
    wire mode_cmd = cmd_live && cmd_code == DBC_CMD_MODE;
    wire pre_all  = addr[DBC_PRE_ALL_BIT];                 // RQ25
    wire [DBC_COL_W-1:0] cmd_col = {addr[DBC_COL_HI_BIT], addr[9:0]};

    wire [DBC_ENT_W-1:0] new_ent = {rd_cmd || wr_cmd, wr_cmd,
                                    addr[DBC_PRE_ALL_BIT], ba, cmd_col};

    // posted reads and writes reach the core after the additive latency
    wire [DBC_ENT_W-1:0] int_ent = (additive_latency == 3'h0) ? new_ent
                         : post_pipe[additive_latency - 3'h1]; // RQ19
    wire                  int_go = int_ent[DBC_ENT_VALID];
    wire                  int_wr = int_ent[DBC_ENT_WR];
    wire                  int_ap = int_ent[DBC_ENT_AP];
    wire [DBC_BA_W-1:0]   int_ba = int_ent[DBC_ENT_BA_LO +: DBC_BA_W];
    wire [DBC_COL_W-1:0]  int_col = int_ent[DBC_COL_W-1:0];
    wire int_rd_go = int_go && !int_wr;
    wire int_wr_go = int_go && int_wr;

    wire dbc_timer_t half   = dbc_half_burst(burst_length_setting);
    wire dbc_timer_t rl_cyc = {3'h0, read_latency_setting};
    // earliest explicit precharge that still keeps every read beat
    wire dbc_timer_t rd_ap_wait = half; // RQ4
    // write latency is one below read latency, then recovery
    wire dbc_timer_t wr_ap_wait = rl_cyc - 6'h01 + half
                                + {3'h0, write_recovery_time}; // RQ5

    // ========================================================
    // write data fifo; drains only while a write burst wants beats
    logic                  fifo_valid;
    logic [DBC_DATA_W+DBC_MASK_W-1:0] fifo_data;
    wire                   fifo_pop = arr_wr_valid && arr_wr_ready;

    dbc_fifo #(
        .WIDTH (DBC_DATA_W + DBC_MASK_W),
        .DEPTH (DBC_FIFO_DEPTH)
    ) u_wfifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .in_valid  (wdata_valid),
        .in_data   ({write_byte_mask, wdata}),
        .in_ready  (wdata_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop)
    );

    wire [DBC_MASK_W-1:0] fifo_mask = fifo_data[DBC_DATA_W +: DBC_MASK_W];
    assign arr_wr_valid   = (wr_left != 4'h0) && fifo_valid;
    assign arr_wr_bank    = wr_bank;
    assign arr_wr_row     = bank_row[wr_bank];
    assign arr_wr_col     = wr_col;
    assign arr_wr_data    = fifo_data[DBC_DATA_W-1:0];
    assign arr_wr_byte_en = ~fifo_mask; // RQ20

    assign rd_busy   = (rd_left != 6'h00);
    assign wr_busy   = (wr_left != 4'h0);
    assign mode_busy = (mode_timer != 6'h00);
    assign mode_data = mode_regs[mode_sel];

    // ========================================================
    // status per bank
    always_comb begin
        for (int b = 0; b < DBC_BANKS; b++) begin
            bank_idle[b] = bank_state[b] == BK_IDLE
                && !(rd_busy && rd_burst_bank == 3'(b)); // RQ2
            bank_row_active[b] = bank_state[b] == BK_ACTIVE && !mode_busy
                && !(rd_busy && rd_burst_bank == 3'(b))
                && !(wr_busy && wr_bank == 3'(b)); // RQ3
        end
    end

    // ========================================================
    // posting pipe and command bookkeeping
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cke_prev <= 1'b0;
            for (int i = 0; i < DBC_POST_DEPTH; i++)
                post_pipe[i] <= '0;
        end else if (clk_en) begin
            cke_prev     <= cke;
            post_pipe[0] <= new_ent; // RQ19
            for (int i = 1; i < DBC_POST_DEPTH; i++)
                post_pipe[i] <= post_pipe[i-1];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_timer <= 6'h00;
            for (int i = 0; i < DBC_MODE_REGS; i++)
                mode_regs[i] <= DBC_MODE_RST;
        end else if (clk_en) begin
            if (mode_cmd) begin
                mode_regs[ba[1:0]] <= addr;  // RQ14
                mode_timer <= DBC_MODE_LOAD_GAP_CYC;
            end else if (mode_busy)
                mode_timer <= mode_timer - 6'h01;
        end
    end

    // refresh rows come from the counter; the address pins are ignored
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_pulse <= 1'b0;
            refresh_row   <= DBC_REF_ROW_RST;
        end else if (clk_en) begin
            refresh_pulse <= ref_cmd; // RQ23
            if (ref_cmd)
                refresh_row <= refresh_row + 15'h0001; // RQ23
        end
    end

    // ========================================================
    // bursts
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_start      <= 1'b0;
            rd_bank       <= '0;
            rd_row        <= '0;
            rd_col        <= '0;
            rd_left       <= 6'h00;
            rd_burst_bank <= '0;
        end else if (clk_en) begin
            rd_start <= int_rd_go; // RQ17
            if (int_rd_go) begin
                rd_bank       <= int_ba;
                rd_row        <= bank_row[int_ba];
                rd_col        <= int_col;
                rd_burst_bank <= int_ba;
                rd_left       <= rl_cyc + half;
            end else if (rd_busy)
                rd_left <= rd_left - 6'h01;
        end
    end

    // beats of a write burst are taken as the fifo supplies them
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_left <= 4'h0;
            wr_bank <= '0;
            wr_col  <= '0;
        end else if (clk_en) begin
            if (int_wr_go) begin // RQ18
                wr_left <= {half[2:0], 1'b0};
                wr_bank <= int_ba;
                wr_col  <= int_col;
            end else if (fifo_pop) begin
                wr_left <= wr_left - 4'h1;
                wr_col  <= wr_col + 11'h001;
            end
        end
    end

    // ========================================================
    // bank state; each bank only sees commands aimed at it, so
    // the others keep running through an auto precharge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < DBC_BANKS; b++) begin
                bank_state[b] <= BK_IDLE;
                bank_timer[b] <= 6'h00;
                bank_row[b]   <= '0;
            end
        end else if (clk_en) begin
            for (int b = 0; b < DBC_BANKS; b++) begin // RQ6
                if (bank_timer[b] != 6'h00)
                    bank_timer[b] <= bank_timer[b] - 6'h01;
                else if (bank_state[b] == BK_OPENING)
                    bank_state[b] <= BK_ACTIVE; // RQ3
                else if (bank_state[b] == BK_AP_WAIT) begin
                    bank_state[b] <= BK_PRECHG; // RQ4 RQ5
                    bank_timer[b] <= 6'(DBC_PRECHARGE_CYC);
                end else if (bank_state[b] == BK_PRECHG)
                    bank_state[b] <= BK_IDLE; // RQ2
                if (act_cmd && ba == 3'(b) && bank_state[b] == BK_IDLE) begin
                    bank_state[b] <= BK_OPENING; // RQ15
                    bank_row[b]   <= addr;
                    bank_timer[b] <= 6'(DBC_ACT_TO_ACCESS_CYC);
                end
                if (pre_cmd && (pre_all || ba == 3'(b))
                        && bank_state[b] != BK_IDLE) begin
                    bank_state[b] <= BK_PRECHG; // RQ21 RQ25
                    bank_timer[b] <= 6'(DBC_PRECHARGE_CYC); // RQ22
                end
                if (int_go && int_ap && int_ba == 3'(b)) begin
                    bank_state[b] <= BK_AP_WAIT;
                    bank_timer[b] <= int_wr ? wr_ap_wait : rd_ap_wait;
                end
            end
        end
    end

    // ========================================================
    // checks
    desel_quiet_a: assert property (@(posedge core_clk) // RQ12
        disable iff (!rst_n)
        (clk_en && cs_n && !mode_busy) |=> !refresh_pulse && !mode_busy)
        else $error("deselect started work");

    nop_quiet_a: assert property (@(posedge core_clk) // RQ13
        disable iff (!rst_n)
        (clk_en && cmd_code == DBC_CMD_NOP) |=> !refresh_pulse)
        else $error("no-operation started work");

    act_opens_a: assert property (@(posedge core_clk) // RQ15
        disable iff (!rst_n)
        (clk_en && act_cmd && bank_idle[ba] && !(int_go && int_ba == ba))
        |=> bank_row[$past(ba)] == $past(addr)
            && !bank_row_active[$past(ba)])
        else $error("activate did not open row");

    pre_closes_a: assert property (@(posedge core_clk) // RQ21
        disable iff (!rst_n)
        (clk_en && pre_cmd && !pre_all && bank_row_active[ba])
        |=> !bank_idle[$past(ba)] && !bank_row_active[$past(ba)])
        else $error("precharge did not close bank");

    refresh_row_a: assert property (@(posedge core_clk) // RQ23
        disable iff (!rst_n)
        (clk_en && ref_cmd)
        |=> refresh_pulse && refresh_row == $past(refresh_row) + 15'h0001)
        else $error("refresh row did not advance");

    mode_load_a: assert property (@(posedge core_clk) // RQ14
        disable iff (!rst_n)
        (clk_en && mode_cmd)
        |=> mode_regs[$past(ba[1:0])] == $past(addr) && mode_busy)
        else $error("mode load lost");

    mask_store_a: assert property (@(posedge core_clk) // RQ20
        disable iff (!rst_n)
        arr_wr_valid |-> (arr_wr_byte_en & fifo_mask) == '0
            && (arr_wr_byte_en | fifo_mask) == '1)
        else $error("byte mask not honoured");

    posted_read_a: assert property (@(posedge core_clk) // RQ19
        disable iff (!rst_n)
        (clk_en && rd_cmd && additive_latency == 3'h2)
        ##1 clk_en ##1 clk_en |=> rd_start)
        else $error("posted read not delayed by latency");

    rd_idle_a: assert property (@(posedge core_clk) // RQ2
        disable iff (!rst_n)
        rd_busy |-> !bank_idle[rd_burst_bank])
        else $error("bank idle during read burst");

endmodule

// ---- tb/dbc_array_model.sv ----
// array side model: takes write beats, stalls on request
`timescale 1ns/1ps
module dbc_array_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // behaviour select
    input  wire logic stall,
    input  wire logic fast,
    // array write handshake
    output logic      arr_wr_ready
);
    logic phase;
    // ========================================================
    // slow mode accepts every other cycle, like a busy array
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) phase <= 1'b0;
        else phase <= ~phase;
    end
    assign arr_wr_ready = ~stall & (fast | phase);
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the bank command logic
`timescale 1ns/1ps
module tb;
    import dbc_pkg::*;
    // ========================================================
    // stimulus and observed signals
    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, cke = 1'b1;
    logic cs_n = 1'b1, ras_n = 1'b1, cas_n = 1'b1, we_n = 1'b1;
    logic [2:0] ba = 3'h0, additive_latency = 3'h0;
    logic [14:0] addr = 15'h0000;
    logic [2:0] read_latency_setting = 3'h3, write_recovery_time = 3'h2;
    logic burst_length_setting = 1'b0, wdata_valid = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] write_byte_mask = 2'h0, mode_sel = 2'h0;
    logic stall = 1'b1, fast = 1'b0;
    logic wdata_ready, arr_wr_valid, arr_wr_ready, rd_start;
    logic refresh_pulse, mode_busy, rd_busy, wr_busy;
    logic [2:0] arr_wr_bank, rd_bank;
    logic [14:0] arr_wr_row, rd_row, refresh_row, mode_data, v;
    logic [10:0] arr_wr_col, rd_col;
    logic [15:0] arr_wr_data;
    logic [1:0] arr_wr_byte_en;
    logic [7:0] bank_idle, bank_row_active;
    logic [14:0] rows [8];
    logic [17:0] mem [8];
    logic [60:0] rdq [$];
    logic [46:0] wrq [$];
    logic [60:0] re;
    logic [46:0] we;
    int cyc = 0, mismatches = 0, checks = 0, seed_v;

    always #25 core_clk = ~core_clk;

    dbc_cmd dbc_cmd_inst (.core_clk, .rst_n, .clk_en, .cke, .cs_n, .ras_n,
        .cas_n, .we_n, .ba, .addr, .read_latency_setting,
        .burst_length_setting, .additive_latency, .write_recovery_time,
        .wdata_valid, .wdata, .write_byte_mask, .wdata_ready, .arr_wr_valid,
        .arr_wr_ready, .arr_wr_bank, .arr_wr_row, .arr_wr_col, .arr_wr_data,
        .arr_wr_byte_en, .rd_start, .rd_bank, .rd_row, .rd_col,
        .refresh_pulse, .refresh_row, .mode_sel, .mode_data, .mode_busy,
        .bank_idle, .bank_row_active, .rd_busy, .wr_busy);
    dbc_array_model dbc_array_model_inst (.core_clk, .rst_n, .stall, .fast,
        .arr_wr_ready);

    // ========================================================
    // shared tasks
    task automatic chk(input string n, input logic [63:0] x,
                       input logic [63:0] y);
        checks++;
        if (x !== y) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one idle falling edge first, so a nop stands between two commands
    task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                       input logic [14:0] a);
        @(negedge core_clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge core_clk);
        {cs_n, ras_n, cas_n, we_n} = DBC_CMD_NOP;
    endtask
    task automatic act(input logic [2:0] b);
        rows[b] = 15'($urandom);
        cmd(DBC_CMD_ACT, b, rows[b]);
    endtask
    // aligned column keeps a burst clear of the column wrap
    task automatic acc(input logic [3:0] c, input logic [2:0] b,
                       input logic ap, input int base);
        logic [14:0] a;
        logic [10:0] col;
        a = 15'($urandom) & 15'h03f0;
        a[10] = ap;
        col = {a[11], a[9:0]};
        if (c == DBC_CMD_READ)
            rdq.push_back({cyc + 2 + (additive_latency == 3'h0 ? 1 :
                32'(additive_latency) + 1), b, rows[b], col});
        else
            for (int i = 0; i < 4; i++)
                wrq.push_back({b, rows[b], 11'(col + i), mem[base + i]});
        cmd(c, b, a);
    endtask
    task automatic wait_idle(input int b);
        for (int k = 0; k < 40 && bank_idle[b] !== 1'b1; k++)
            @(negedge core_clk);
    endtask

    // ========================================================
    // result watcher: oldest note against each result seen
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (rd_start === 1'b1) begin
            re = rdq.size() > 0 ? rdq.pop_front() : '0;
            chk("rd_start", re, {cyc[31:0], rd_bank, rd_row, rd_col});
        end
        if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1) begin
            we = wrq.size() > 0 ? wrq.pop_front() : '0;
            chk("arr_wr", we,
                {arr_wr_bank, arr_wr_row, arr_wr_col, arr_wr_data, arr_wr_byte_en});
        end
    end

    initial begin
        #1000000;
        mismatches++;
        give_verdict;
    end

    initial begin
        seed_v = $urandom(32'h2d5608fc);
        fast = 1'($urandom);
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        v = 15'($urandom);
        cmd(DBC_CMD_MODE, 3'h1, v);
        chk("mode_busy", 1'b1, mode_busy);
        mode_sel = 2'h1;
        repeat (3) @(negedge core_clk);
        chk("mode_data", v, mode_data);
        cmd(DBC_CMD_REF, 3'h0, 15'($urandom));
        chk("refresh_pulse", 1'b1, refresh_pulse);
        repeat (2) @(negedge core_clk);
        chk("refresh_row", 15'h0001, refresh_row);
        $display("test mode_refresh done");
        cke = 1'b0;
        cmd(DBC_CMD_ACT, 3'h2, 15'h0000);
        fork
            cmd(DBC_CMD_ACT, 3'h2, 15'h0000);
            @(negedge core_clk) cke = 1'b1;
        join
        cmd(4'hb, 3'h2, 15'h0000);
        repeat (3) @(negedge core_clk);
        chk("bank_idle", 8'hff, bank_idle);
        $display("test gated done");
        act(3'h2);
        repeat (2) @(negedge core_clk);
        chk("bank_row_active", 8'h04, bank_row_active);
        acc(DBC_CMD_READ, 3'h2, 1'b0, 0);
        chk("rd_busy", 1'b1, rd_busy);
        repeat (8) @(negedge core_clk);
        chk("bank_row_active", 8'h04, bank_row_active);
        $display("test read done");
        // far side stalled: fifo must refuse its ninth word
        for (int i = 0; i < 8; i++) begin
            wdata_valid = 1'b1;
            wdata = 16'($urandom);
            write_byte_mask = 2'($urandom);
            mem[i] = {wdata, ~write_byte_mask};
            @(negedge core_clk);
        end
        wdata_valid = 1'b0;
        chk("wdata_ready", 1'b0, wdata_ready);
        acc(DBC_CMD_WRITE, 3'h2, 1'b0, 0);
        chk("wr_busy", 1'b1, wr_busy);
        repeat (3) @(negedge core_clk);
        stall = 1'b0;
        for (int k = 0; k < 40 && wr_busy !== 1'b0; k++) @(negedge core_clk);
        acc(DBC_CMD_WRITE, 3'h2, 1'b1, 4);
        wait_idle(2);
        chk("bank_idle", 1'b1, bank_idle[2]);
        chk("wdata_ready", 1'b1, wdata_ready);
        $display("test write done");
        additive_latency = 3'h2;
        act(3'h5);
        repeat (2) @(negedge core_clk);
        acc(DBC_CMD_READ, 3'h5, 1'b1, 0);
        act(3'h6);
        wait_idle(5);
        chk("bank_idle", 1'b1, bank_idle[5]);
        chk("bank_row_active", 1'b1, bank_row_active[6]);
        additive_latency = 3'h0;
        $display("test posted done");
        act(3'h1);
        act(3'h3);
        repeat (2) @(negedge core_clk);
        cmd(DBC_CMD_PRE, 3'h4, 15'h0000);
        repeat (2) @(negedge core_clk);
        chk("bank_row_active", 8'h4a, bank_row_active);
        cmd(DBC_CMD_PRE, 3'h6, 15'h0000);
        chk("bank_row_active", 8'h0a, bank_row_active);
        cmd(DBC_CMD_PRE, 3'h0, 15'h0400);
        repeat (3) @(negedge core_clk);
        chk("bank_idle", 8'hff, bank_idle);
        $display("test precharge done");
        chk("queues", 0, rdq.size() + wrq.size());
        give_verdict;
    end
endmodule
